// ===== pacpd_consts.vh
// constants for the auxiliary control and phase detect block
`ifndef PACPD_CONSTS_VH
`define PACPD_CONSTS_VH
`define PACPD_AUX_WIDTH 8
`define PACPD_AUX_RESET 8'h00
`define PACPD_BIT_FP_OUT 2
`define PACPD_BIT_PWR_DOWN 3
`define PACPD_BIT_CNT_LOAD 4
`define PACPD_BIT_MODULUS_SELECT_OUT 5
`define PACPD_BIT_FC_OUT 6
`define PACPD_LOCK_ACC_WIDTH 8
`define PACPD_LOCK_THRESH 8'hC0
`endif

// ===== pacpd_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pacpd_sync #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] d_i,
  output reg [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= {WIDTH{1'b0}};
      q_o <= {WIDTH{1'b0}};
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // pacpd_sync

// ===== pacpd_pfd.v
// tri-state phase-frequency detector on synchronised divider edges
`timescale 1ns/1ps
module pacpd_pfd (
  input wire clk_i,
  input wire rst_i,
  input wire enable_i,
  input wire fp_rise_i,
  input wire fc_rise_i,
  output reg up_n_o,
  output reg down_n_o
);
  reg up;
  reg down;
  reg next_up;
  reg next_down;
  // ----------------------------------------
  // detector state
  // ----------------------------------------
  always @* begin
    next_up = up | fc_rise_i;
    next_down = down | fp_rise_i;
    if (!enable_i || (next_up && next_down)) begin
      next_up = 1'b0; // width tracks phase offset
      next_down = 1'b0;
    end
  end
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      up <= 1'b0;
      down <= 1'b0;
      up_n_o <= 1'b1;
      down_n_o <= 1'b1;
    end else begin
      up <= next_up;
      down <= next_down;
      up_n_o <= ~next_up;
      down_n_o <= ~next_down;
    end
  end
endmodule // pacpd_pfd

// ===== pacpd_top.v
// auxiliary control register, diagnostic mux, phase detector and lock detect
// Functional notes
// - each auxiliary bit acts when one, inactive when zero
// - bit 2 puts main divider output on diagnostic pin
// - bit 3 powers down all but programming interface
// - bit 4 loads counters immediately and continuously
// - bit 5 puts modulus select on diagnostic pin
// - bit 6 puts reference divider output on diagnostic pin
// - detector acts only on rising edges of both divided inputs
// - select high gives pump pulses, low gives detector outputs
// - main divider leading pulses down output low
// - reference divider leading pulses up output low
// - pulse width proportional to phase difference
// - up raises oscillator frequency, down lowers it
// - up enables pump source current, down enables sink
// - lock filter node is NAND of up and down outputs
// - lock pin is inverted integrated node, open drain
// - shifted byte loads into register on write strobe fall
// - register bits act only while enable input low
`timescale 1ns/1ps
`include "pacpd_consts.vh"
module pacpd_top (
  input wire CORE_CLK_I,
  input wire RST_I,
  input wire [7:0] SHIFT_DATA_I,
  input wire AUX_WRITE_STROBE_I,
  input wire AUX_ENABLE_N_I,
  input wire PUMP_OR_DETECTOR_SELECT_I,
  input wire MAIN_DIV_I,
  input wire REF_DIV_I,
  input wire MODULUS_SELECT_I,
  output reg DIAG_OUT_O,
  output reg POWER_DOWN_O,
  output reg COUNTER_LOAD_O,
  output reg PHASE_UP_N_O,
  output reg PHASE_DOWN_N_O,
  output reg PUMP_SOURCE_O,
  output reg PUMP_SINK_O,
  output reg LOCK_FILTER_NODE_O,
  output wire LOCK_INDICATOR_O,
  output reg LOCK_INDICATOR_OE_N_O,
  output wire [7:0] AUX_CONTROL_O
);

  // ----------------------------------------
  // local constants
  // ----------------------------------------
  localparam AUX_W = `PACPD_AUX_WIDTH;
  localparam ACC_W = `PACPD_LOCK_ACC_WIDTH;
  localparam [ACC_W-1:0] ACC_ZERO = {ACC_W{1'b0}};
  localparam [ACC_W-1:0] ACC_FULL = {ACC_W{1'b1}};
  localparam [ACC_W-1:0] ACC_STEP = {{(ACC_W-1){1'b0}}, 1'b1};
  localparam [ACC_W-1:0] ACC_THRESH = `PACPD_LOCK_THRESH;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // one control bit, live only while enabled
  function aux_bit;
    input [AUX_W-1:0] word;
    input active;
    input integer pos;
    begin
      aux_bit = active & word[pos];
    end
  endfunction

  // diagnostic source; fixed priority only under misuse
  function diag_pick;
    input [AUX_W-1:0] word;
    input active;
    input fp;
    input modulus_select;
    input fc;
    begin
      diag_pick = 1'b0;
      if (aux_bit(word, active, `PACPD_BIT_FP_OUT)) begin
        diag_pick = fp;
      end else if (aux_bit(word, active, `PACPD_BIT_MODULUS_SELECT_OUT)) begin
        diag_pick = modulus_select;
      end else if (aux_bit(word, active, `PACPD_BIT_FC_OUT)) begin
        diag_pick = fc;
      end
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [7:0] data_s;
  wire [5:0] pins_s;
  pacpd_sync #(.WIDTH(8)) u_sync_data (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .d_i(SHIFT_DATA_I),
    .q_o(data_s)
  );
  pacpd_sync #(.WIDTH(6)) u_sync_pins (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .d_i({AUX_WRITE_STROBE_I, AUX_ENABLE_N_I, PUMP_OR_DETECTOR_SELECT_I,
          MAIN_DIV_I, REF_DIV_I, MODULUS_SELECT_I}),
    .q_o(pins_s)
  );
  wire strobe_s = pins_s[5];
  wire enable_n_s = pins_s[4];
  wire pump_sel_s = pins_s[3];
  wire main_s = pins_s[2];
  wire ref_s = pins_s[1];
  wire modulus_select_s = pins_s[0];

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  localparam EDGE_COUNT = 3;
  localparam EDGE_REF = 0;
  localparam EDGE_MAIN = 1;
  localparam EDGE_STROBE = 2;
  wire [EDGE_COUNT-1:0] edge_now = {strobe_s, main_s, ref_s};
  wire [EDGE_COUNT-1:0] edge_last;

  genvar g;
  generate
    for (g = 0; g < EDGE_COUNT; g = g + 1) begin : g_edge
      // resets to the idle low level, so no false edge after reset
      reg last;
      always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
          last <= 1'b0;
        end else begin
          last <= edge_now[g];
        end
      end
      assign edge_last[g] = last;
    end
  endgenerate

  wire strobe_fall = edge_last[EDGE_STROBE] & ~strobe_s;
  wire main_rise = main_s & ~edge_last[EDGE_MAIN];
  wire ref_rise = ref_s & ~edge_last[EDGE_REF];

  // ----------------------------------------
  // auxiliary control register
  // ----------------------------------------
  reg [AUX_W-1:0] aux_control;
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aux_control <= `PACPD_AUX_RESET;
    end else if (strobe_fall) begin
      aux_control <= data_s; // reserved bits stored as written
    end
  end
  assign AUX_CONTROL_O = aux_control;

  // bits only act while enable is low; stored value kept otherwise
  wire aux_active = ~enable_n_s;
  wire pwr_down = aux_bit(aux_control, aux_active, `PACPD_BIT_PWR_DOWN);
  wire cnt_load = aux_bit(aux_control, aux_active, `PACPD_BIT_CNT_LOAD);

  // ----------------------------------------
  // phase detector
  // ----------------------------------------
  // detector idles while powered down
  wire up_n;
  wire down_n;
  pacpd_pfd u_pfd (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .enable_i(~pwr_down),
    .fp_rise_i(main_rise),
    .fc_rise_i(ref_rise),
    .up_n_o(up_n),
    .down_n_o(down_n)
  );

  // ----------------------------------------
  // diagnostic pin
  // ----------------------------------------
  reg next_diag;
  always @* begin
    // priority only matters under misuse, which is undefined
    next_diag = diag_pick(aux_control, aux_active, main_s, modulus_select_s, ref_s);
    if (pwr_down) begin
      next_diag = 1'b0;
    end
  end

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DIAG_OUT_O <= 1'b0;
    end else begin
      DIAG_OUT_O <= next_diag;
    end
  end

  // ----------------------------------------
  // power down and counter load
  // ----------------------------------------
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      POWER_DOWN_O <= 1'b0;
    end else begin
      POWER_DOWN_O <= pwr_down;
    end
  end

  // counter load held off while powered down
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      COUNTER_LOAD_O <= 1'b0;
    end else begin
      COUNTER_LOAD_O <= cnt_load & ~pwr_down;
    end
  end

  // ----------------------------------------
  // detector pins
  // ----------------------------------------
  // pins idle high while the pump is selected
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PHASE_UP_N_O <= 1'b1;
    end else begin
      PHASE_UP_N_O <= pump_sel_s ? 1'b1 : up_n;
    end
  end

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PHASE_DOWN_N_O <= 1'b1;
    end else begin
      PHASE_DOWN_N_O <= pump_sel_s ? 1'b1 : down_n;
    end
  end

  // ----------------------------------------
  // charge pump switches
  // ----------------------------------------
  // source and sink never on together: the detector clears both
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PUMP_SOURCE_O <= 1'b0;
    end else begin
      PUMP_SOURCE_O <= pump_sel_s & ~up_n;
    end
  end

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PUMP_SINK_O <= 1'b0;
    end else begin
      PUMP_SINK_O <= pump_sel_s & ~down_n;
    end
  end

  // ----------------------------------------
  // lock filter node and integration
  // ----------------------------------------
  reg [ACC_W-1:0] lock_acc;
  reg [ACC_W-1:0] next_lock_acc;
  wire node_high = ~(up_n & down_n);

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      LOCK_FILTER_NODE_O <= 1'b0;
    end else begin
      LOCK_FILTER_NODE_O <= node_high;
    end
  end

  // saturating up/down count stands in for the external capacitor
  always @* begin
    next_lock_acc = lock_acc;
    if (node_high) begin
      if (lock_acc != ACC_FULL) begin
        next_lock_acc = lock_acc + ACC_STEP;
      end
    end else if (lock_acc != ACC_ZERO) begin
      next_lock_acc = lock_acc - ACC_STEP;
    end
  end

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lock_acc <= ACC_ZERO;
    end else begin
      lock_acc <= next_lock_acc;
    end
  end

  // open drain pulls low while node integrates high
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      LOCK_INDICATOR_OE_N_O <= 1'b1;
    end else begin
      LOCK_INDICATOR_OE_N_O <= ~(lock_acc >= ACC_THRESH);
    end
  end

  // pin only ever pulls low; released it reads as locked
  assign LOCK_INDICATOR_O = 1'b0;
endmodule // pacpd_top

// ===== pacpd_sva.sv
// assertions on the top module ports
`timescale 1ns/1ps
module pacpd_sva (
  input wire CORE_CLK_I,
  input wire RST_I,
  input wire MAIN_DIV_I,
  input wire REF_DIV_I,
  input wire PUMP_OR_DETECTOR_SELECT_I,
  input wire DIAG_OUT_O,
  input wire POWER_DOWN_O,
  input wire COUNTER_LOAD_O,
  input wire PHASE_UP_N_O,
  input wire PHASE_DOWN_N_O,
  input wire PUMP_SOURCE_O,
  input wire PUMP_SINK_O,
  input wire LOCK_FILTER_NODE_O,
  input wire LOCK_INDICATOR_O,
  input wire LOCK_INDICATOR_OE_N_O,
  input wire [7:0] AUX_CONTROL_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_idle;
    !PUMP_OR_DETECTOR_SELECT_I && !POWER_DOWN_O && PHASE_UP_N_O && PHASE_DOWN_N_O;
  endsequence
  sequence s_ref_lead;
    s_idle ##0 $rose(REF_DIV_I) && !MAIN_DIV_I && !$past(MAIN_DIV_I) && !$past(MAIN_DIV_I, 2);
  endsequence
  sequence s_main_lead;
    s_idle ##0 $rose(MAIN_DIV_I) && !REF_DIV_I && !$past(REF_DIV_I) && !$past(REF_DIV_I, 2);
  endsequence
  property p_up; s_ref_lead |-> ##[2:4] !PHASE_UP_N_O; endproperty
  property p_down; s_main_lead |-> ##[2:4] !PHASE_DOWN_N_O; endproperty
  property p_pwr; POWER_DOWN_O |-> $past(AUX_CONTROL_O[3]); endproperty
  property p_load; COUNTER_LOAD_O |-> $past(AUX_CONTROL_O[4]) && !POWER_DOWN_O; endproperty
  property p_diag; DIAG_OUT_O |-> $past(|(AUX_CONTROL_O & 8'h64)); endproperty
  property p_sel; PUMP_SOURCE_O || PUMP_SINK_O |-> PHASE_UP_N_O && PHASE_DOWN_N_O; endproperty
  property p_nand; !(PHASE_UP_N_O && PHASE_DOWN_N_O) |-> LOCK_FILTER_NODE_O; endproperty
  property p_lock; !LOCK_INDICATOR_O; endproperty
  property p_pull; $fell(LOCK_INDICATOR_OE_N_O) |-> $past(LOCK_FILTER_NODE_O); endproperty
  property p_release; $rose(LOCK_INDICATOR_OE_N_O) |-> !$past(LOCK_FILTER_NODE_O); endproperty
  a_up: assert property (p_up) else $error("no up pulse");
  a_down: assert property (p_down) else $error("no down pulse");
  a_pwr: assert property (p_pwr) else $error("bad power down");
  a_load: assert property (p_load) else $error("bad counter load");
  a_diag: assert property (p_diag) else $error("bad diag");
  a_sel: assert property (p_sel) else $error("pump and pins both active");
  a_nand: assert property (p_nand) else $error("bad filter node");
  a_lock: assert property (p_lock) else $error("lock pin drives high");
  a_pull: assert property (p_pull) else $error("lock pull without node high");
  a_release: assert property (p_release) else $error("lock release with node high");
endmodule // pacpd_sva

// ===== pacpd_loop_model.sv
// loop filter and oscillator tune model fed by the pump
`timescale 1ns/1ps
module pacpd_loop_model (
  input wire clk_i,
  input wire rst_i,
  input wire source_i,
  input wire sink_i,
  output reg [7:0] tune_o
);
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tune_o <= 8'h80;
    end else begin
      tune_o <= tune_o + {7'h00, source_i} - {7'h00, sink_i};
    end
  end
endmodule // pacpd_loop_model

// ===== pacpd_top_tb.sv
// self-checking bench for the auxiliary control and phase detect block
`timescale 1ns/1ps
module pacpd_top_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] data = 8'h00;
  reg strobe = 1'b0, en_n = 1'b0, sel = 1'b0, fp = 1'b0, fc = 1'b0, modulus_select = 1'b0;
  wire diag, pwr, load, up_n, dn_n, src, snk, node, ld, ld_oe_n;
  wire [7:0] aux, tune;
  integer err_total = 0, checked = 0, cycles = 0, b;
  always #10 clk = ~clk;
  pacpd_top pacpd_top_i (.CORE_CLK_I(clk), .RST_I(rst), .SHIFT_DATA_I(data),
    .AUX_WRITE_STROBE_I(strobe), .AUX_ENABLE_N_I(en_n), .PUMP_OR_DETECTOR_SELECT_I(sel),
    .MAIN_DIV_I(fp), .REF_DIV_I(fc), .MODULUS_SELECT_I(modulus_select), .DIAG_OUT_O(diag),
    .POWER_DOWN_O(pwr), .COUNTER_LOAD_O(load), .PHASE_UP_N_O(up_n), .PHASE_DOWN_N_O(dn_n),
    .PUMP_SOURCE_O(src), .PUMP_SINK_O(snk), .LOCK_FILTER_NODE_O(node),
    .LOCK_INDICATOR_O(ld), .LOCK_INDICATOR_OE_N_O(ld_oe_n), .AUX_CONTROL_O(aux));
  pacpd_loop_model pacpd_loop_model_i (.clk_i(clk), .rst_i(rst), .source_i(src),
    .sink_i(snk), .tune_o(tune));
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task write_aux(input [7:0] v);
    begin
      @(posedge clk) data <= v;
      strobe <= 1'b1;
      tick(4);
      @(posedge clk) strobe <= 1'b0;
      tick(8);
    end
  endtask
  task t_bits;
    begin
      @(posedge clk) fp <= 1'b1;
      fc <= 1'b1;
      modulus_select <= 1'b1;
      for (b = 2; b < 7; b = b + 1) begin
        write_aux(8'h01 << b);
        chk(aux, 8'h01 << b);
        chk(diag, b == 2 || b == 5 || b == 6);
        chk(pwr, b == 3);
        chk(load, b == 4);
      end
      @(posedge clk) en_n <= 1'b1;
      tick(6);
      chk(diag, 8'h00);
      chk(aux, 8'h40);
      write_aux(8'h00);
      @(posedge clk) en_n <= 1'b0;
      fp <= 1'b0;
      fc <= 1'b0;
      tick(6);
    end
  endtask
  task t_pfd(input ref_first, input pump);
    begin
      @(posedge clk) sel <= pump;
      tick(4);
      @(posedge clk) if (ref_first) fc <= 1'b1; else fp <= 1'b1;
      tick(5);
      chk(up_n, pump | !ref_first);
      chk(dn_n, pump | ref_first);
      chk({src, snk}, {pump & ref_first, pump & !ref_first});
      chk(node, 8'h01);
      @(posedge clk) fp <= 1'b1;
      fc <= 1'b1;
      tick(5);
      chk({up_n, dn_n, src, snk}, 8'h0C);
      @(posedge clk) fp <= 1'b0;
      fc <= 1'b0;
      tick(5);
      chk({up_n, dn_n}, 8'h03);
    end
  endtask
  task t_lock;
    begin
      @(posedge clk) sel <= 1'b0;
      tick(4);
      chk(ld_oe_n, 8'h01);
      @(posedge clk) fc <= 1'b1;
      tick(220);
      chk({ld, ld_oe_n, node}, 8'h01);
      @(posedge clk) fp <= 1'b1;
      tick(100);
      chk({ld, ld_oe_n, node}, 8'h02);
      @(posedge clk) fp <= 1'b0;
      fc <= 1'b0;
      tick(4);
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    t_bits;
    t_pfd(1'b1, 1'b0);
    t_pfd(1'b0, 1'b0);
    t_pfd(1'b1, 1'b1);
    chk(tune > 8'h80, 8'h01);
    t_pfd(1'b0, 1'b1);
    chk(tune, 8'h80);
    t_lock;
    give_verdict;
  end
endmodule // pacpd_top_tb
bind pacpd_top pacpd_sva pacpd_sva_i (.*);
